// File: mrpc_checker.sv
// Bus checks for the link between the device end and the peer end.
// Assumes one clock, frames of ten bits of 400 cycles each.
`timescale 1ns/1ps
module mrpc_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic peer_out,
  input wire logic peer_oe,
  input wire logic bus_level,
  input wire logic group_enable
);
  // ========
  // Frame position of each sender, 0 while idle
  logic [11:0] dev_pos_reg;
  logic [11:0] peer_pos_reg;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      dev_pos_reg <= 12'h000;
    else if (dev_pos_reg != 12'h000 || dev_oe)
      dev_pos_reg <= dev_pos_reg == 12'hF9F ? 12'h000 : dev_pos_reg + 12'h001;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      peer_pos_reg <= 12'h000;
    else if (peer_pos_reg != 12'h000 || peer_oe)
      peer_pos_reg <= peer_pos_reg == 12'hF9F ? 12'h000
                      : peer_pos_reg + 12'h001;

  // ========
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence low_s(logic oe);
    oe ##0 !bus_level;
  endsequence
  property start_p(logic [11:0] pos, logic oe);
    pos inside {[12'h001:12'h18F]} |-> low_s(oe);
  endproperty
  property stop_p(logic [11:0] pos, logic oe);
    pos >= 12'hE10 |-> !oe;
  endproperty
  property bit_edge_p(logic [11:0] pos, logic oe);
    pos != 12'h000 && pos % 12'h190 != 12'h000 |-> $stable(oe);
  endproperty

  dev_start_bit_a: assert property (start_p(dev_pos_reg, dev_oe))
    else $error("device start bit not held");
  dev_stop_bit_a: assert property (stop_p(dev_pos_reg, dev_oe))
    else $error("device stop bit not released");
  dev_bit_time_a: assert property (bit_edge_p(dev_pos_reg, dev_oe))
    else $error("device bit changed inside bit time");
  peer_start_bit_a: assert property (start_p(peer_pos_reg, peer_oe))
    else $error("peer start bit not held");
  peer_stop_bit_a: assert property (stop_p(peer_pos_reg, peer_oe))
    else $error("peer stop bit not released");
  peer_bit_time_a: assert property(bit_edge_p(peer_pos_reg, peer_oe))
    else $error("peer bit changed inside bit time");
  dev_drain_only_a: assert property (!dev_out)
    else $error("device drives the bus high");
  peer_drain_only_a: assert property (!peer_out)
    else $error("peer drives the bus high");
  wired_line_a: assert property (bus_level == !(dev_oe || peer_oe))
    else $error("bus level not wired low");
endmodule

// File: mrpc_device.sv
// Coordination end of a point-of-load converter: strap address,
// phase offset, tracking reference, sequencing and fault spreading.
// Assumes tracking and target levels and fault_in are on clk;
// strap, enable and bus pins are asynchronous.
//
// Summary of operation
// R1 - Resistor strap picks address 0x19 to 0x31
// R2 - Ground 0x23, open 0x24, regulator 0x25
// R3 - One shared bus carries group messages
// R4 - System wires bus with single pull-up
// R5 - Phase offset in sixteenth-turn steps by command
// R6 - System gives all converters one switching clock
// R7 - Tracking enabled only by command, reference input
// R8 - Coincident: follow input, stop at target optional
// R9 - Ratiometric: fixed fraction, default half
// R10 - Output-limited ratio stops at target fraction
// R11 - Tracking-limited: fraction of input, capped target
// R12 - Command-held preceding and following device ids
// R13 - Tied enables: rise sequences up, fall down
// R14 - Own fault: shut down, broadcast if spreading
// R15 - Heard fault: shut down, optionally restart
// R16 - Strap sampled once after reset, then held
`timescale 1ns/1ps
module mrpc_device (
  input  wire logic        clk,
  input  wire logic        rstn,
  mrpc_link_if.device      link,
  input  wire logic [1:0]  strap_kind,
  input  wire logic [4:0]  strap_index,
  input  wire logic        ratio_strap_valid,
  input  wire logic [7:0]  ratio_strap,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_code,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        fault_in,
  input  wire logic [11:0] tracking_reference_input,
  input  wire logic [11:0] output_target_level,
  output logic [6:0]       bus_address,
  output logic [3:0]       phase_offset,
  output logic             rail_on,
  output logic [11:0]      reference_level,
  output logic [2:0]       seq_state
);
  logic [15:0] strap_s1_reg, strap_s2_reg;
  logic [1:0]  strap_cnt_reg;
  logic        strap_done_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  ratio_reg;
  logic [3:0]  phase_reg;
  logic [2:0]  track_reg;
  logic [1:0]  fcfg_reg;
  logic [7:0]  prev_reg, next_reg;
  logic [1:0]  en_s_reg;
  logic        line_s1_reg, line_s2_reg, line_d_reg;
  logic        tx_busy_reg;
  logic [8:0]  tx_shift_reg;
  logic [3:0]  tx_bit_reg;
  logic [9:0]  tx_cnt_reg;
  logic        rx_busy_reg;
  logic [3:0]  rx_bit_reg;
  logic [9:0]  rx_cnt_reg;
  logic [7:0]  rx_shift_reg;
  logic        rx_done_reg;
  logic        up_pend_reg, down_pend_reg, fault_pend_reg;
  logic        rail_reg;
  logic [11:0] ref_reg, ref_next;
  logic [19:0] trk_prod, tgt_prod;
  logic [11:0] trk_frac, tgt_frac;
  logic        tx_start;
  logic [1:0]  tx_type;
  logic        heard_up, heard_down, heard_fault;
  mrpc_pkg::mrpc_state_type state_reg;

  // ==========================================================
  // Strap capture; pins settle through two flops first
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      strap_s1_reg <= 16'h0000;
      strap_s2_reg <= 16'h0000;
    end
    else
    begin
      strap_s1_reg <= {ratio_strap_valid, ratio_strap, strap_kind,
                       strap_index};
      strap_s2_reg <= strap_s1_reg;
    end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      addr_reg       <= mrpc_pkg::ADDR_LOWEST;
    end
    else if (!strap_done_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == mrpc_pkg::STRAP_SETTLE)
      begin
        strap_done_reg <= 1'b1;  // see R16
        case (strap_s2_reg[6:5])
          mrpc_pkg::STRAP_SIGNAL_GROUND:   addr_reg <= mrpc_pkg::ADDR_SIGNAL_GROUND;  // see R2
          mrpc_pkg::STRAP_OPEN:   addr_reg <= mrpc_pkg::ADDR_OPEN;  // see R2
          mrpc_pkg::STRAP_REGOUT: addr_reg <= mrpc_pkg::ADDR_REGOUT;  // see R2
          default:
            if (strap_s2_reg[4:0] > mrpc_pkg::STRAP_LAST_IDX)
              addr_reg <= mrpc_pkg::ADDR_HIGHEST;  // see R1
            else
              addr_reg <= mrpc_pkg::ADDR_LOWEST
                          + {2'b00, strap_s2_reg[4:0]};  // see R1
        endcase
      end
    end

  // ==========================================================
  // Command-held configuration
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      phase_reg <= mrpc_pkg::PHASE_RESET;
      track_reg <= mrpc_pkg::TRACK_RESET;
      ratio_reg <= mrpc_pkg::RATIO_RESET;
      fcfg_reg  <= mrpc_pkg::FAULT_RESET;
      prev_reg  <= 8'h00;
      next_reg  <= 8'h00;
    end
    else if (cmd_valid)
      case (cmd_code)
        mrpc_pkg::CMD_PHASE:     phase_reg <= cmd_data[3:0];  // see R5
        mrpc_pkg::CMD_TRACK_CFG: track_reg <= cmd_data[2:0];  // see R7
        mrpc_pkg::CMD_TRACK_RAT: ratio_reg <= cmd_data;  // see R9
        mrpc_pkg::CMD_PREV_ID:   prev_reg  <= cmd_data;  // see R12
        mrpc_pkg::CMD_NEXT_ID:   next_reg  <= cmd_data;  // see R12
        mrpc_pkg::CMD_FAULT_CFG: fcfg_reg  <= cmd_data[1:0];  // see R14
        default:                 phase_reg <= phase_reg;
      endcase
    else if (!strap_done_reg && strap_cnt_reg == mrpc_pkg::STRAP_SETTLE
             && strap_s2_reg[15])
      ratio_reg <= strap_s2_reg[14:7];  // see R9

  // ==========================================================
  // Tracking reference; trimmed fractions in 1/256 units
  assign trk_prod = tracking_reference_input * ratio_reg;
  assign tgt_prod = output_target_level * ratio_reg;
  assign trk_frac = trk_prod[19:8];
  assign tgt_frac = tgt_prod[19:8];

  always_comb
  begin
    ref_next = output_target_level;
    if (track_reg[mrpc_pkg::TRK_EN_BIT])  // see R7
    begin
      if (!track_reg[mrpc_pkg::TRK_RATIO_BIT])
      begin
        if (track_reg[mrpc_pkg::TRK_LIMIT_BIT])
          ref_next = tracking_reference_input;  // see R8
        else if (tracking_reference_input < output_target_level)
          ref_next = tracking_reference_input;  // see R8
      end
      else if (track_reg[mrpc_pkg::TRK_LIMIT_BIT])
        ref_next = (trk_frac < output_target_level) ? trk_frac
                   : output_target_level;  // see R11
      else
        ref_next = (trk_frac < tgt_frac) ? trk_frac : tgt_frac;  // see R10
    end
  end

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ref_reg <= 12'h000;
    else
      ref_reg <= ref_next;

  // ==========================================================
  // Bus and enable pins, two flops before use
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      line_s1_reg <= 1'b1;
      line_s2_reg <= 1'b1;
      line_d_reg  <= 1'b1;
      en_s_reg    <= 2'b00;
    end
    else
    begin
      line_s1_reg <= link.bus_level;
      line_s2_reg <= line_s1_reg;
      line_d_reg  <= line_s2_reg;
      en_s_reg    <= {en_s_reg[0], link.group_enable};
    end

  // ==========================================================
  // Receiver; own frames are ignored while transmitting
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rx_busy_reg  <= 1'b0;
      rx_bit_reg   <= 4'h0;
      rx_cnt_reg   <= 10'h000;
      rx_shift_reg <= 8'h00;
      rx_done_reg  <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (!rx_busy_reg)
      begin
        if (line_d_reg && !line_s2_reg)
        begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg  <= 4'h0;
          rx_cnt_reg  <= 10'h000;
        end
      end
      else
      begin
        if (rx_cnt_reg == mrpc_pkg::BIT_CYC - 10'h001)
        begin
          rx_cnt_reg <= 10'h000;
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        else
          rx_cnt_reg <= rx_cnt_reg + 10'h001;
        if (rx_cnt_reg == mrpc_pkg::HALF_CYC)
        begin
          if (rx_bit_reg == 4'h0)
            rx_busy_reg <= !line_s2_reg;
          else
            rx_shift_reg <= {rx_shift_reg[6:0], line_s2_reg};
          if (rx_bit_reg == mrpc_pkg::LAST_DATA_BIT)
          begin
            rx_busy_reg <= 1'b0;
            rx_done_reg <= !tx_busy_reg;  // see R3
          end
        end
      end
    end

  assign heard_fault = rx_done_reg
                       && rx_shift_reg[7:6] == mrpc_pkg::MSG_FAULT;
  assign heard_up    = rx_done_reg && prev_reg[mrpc_pkg::ID_VALID_BIT]
                       && rx_shift_reg[7:6] == mrpc_pkg::MSG_UP
                       && rx_shift_reg[5:0] == prev_reg[5:0];
  assign heard_down  = rx_done_reg && next_reg[mrpc_pkg::ID_VALID_BIT]
                       && rx_shift_reg[7:6] == mrpc_pkg::MSG_DOWN
                       && rx_shift_reg[5:0] == next_reg[5:0];

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      state_reg <= mrpc_pkg::ST_OFF;
    else
      case (state_reg)
        mrpc_pkg::ST_OFF:
          if (en_s_reg[1])
            state_reg <= mrpc_pkg::ST_WAIT_UP;  // see R13
        mrpc_pkg::ST_WAIT_UP:
          if (fault_in || heard_fault)
            state_reg <= mrpc_pkg::ST_FAULT;  // see R14
          else if (!en_s_reg[1])
            state_reg <= mrpc_pkg::ST_OFF;
          else if (!prev_reg[mrpc_pkg::ID_VALID_BIT] || heard_up)
            state_reg <= mrpc_pkg::ST_ON;  // see R13
        mrpc_pkg::ST_ON:
          if (fault_in || heard_fault)
            state_reg <= mrpc_pkg::ST_FAULT;  // see R15
          else if (!en_s_reg[1])
            state_reg <= mrpc_pkg::ST_WAIT_DOWN;  // see R13
        mrpc_pkg::ST_WAIT_DOWN:
          if (fault_in || heard_fault)
            state_reg <= mrpc_pkg::ST_FAULT;
          else if (!next_reg[mrpc_pkg::ID_VALID_BIT] || heard_down)
            state_reg <= mrpc_pkg::ST_OFF;  // see R13
        mrpc_pkg::ST_FAULT:
          if (!en_s_reg[1])
            state_reg <= mrpc_pkg::ST_OFF;
          else if (fcfg_reg[mrpc_pkg::FLT_RESTART_BIT] && !fault_in)
            state_reg <= mrpc_pkg::ST_WAIT_UP;  // see R15
        default:
          state_reg <= mrpc_pkg::ST_OFF;
      endcase

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      rail_reg <= 1'b0;
    else
      rail_reg <= (state_reg == mrpc_pkg::ST_ON
                   || state_reg == mrpc_pkg::ST_WAIT_DOWN)
                  && !fault_in && !heard_fault;  // see R15

  // ==========================================================
  // Message requests; a new event wins over the send clear
  assign tx_start = !tx_busy_reg && !rx_busy_reg && line_s2_reg
                    && (up_pend_reg || down_pend_reg || fault_pend_reg);
  assign tx_type  = fault_pend_reg ? mrpc_pkg::MSG_FAULT
                    : up_pend_reg ? mrpc_pkg::MSG_UP : mrpc_pkg::MSG_DOWN;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      up_pend_reg    <= 1'b0;
      down_pend_reg  <= 1'b0;
      fault_pend_reg <= 1'b0;
    end
    else
    begin
      if (tx_start && tx_type == mrpc_pkg::MSG_FAULT)
        fault_pend_reg <= 1'b0;
      if (tx_start && tx_type == mrpc_pkg::MSG_UP)
        up_pend_reg <= 1'b0;
      if (tx_start && tx_type == mrpc_pkg::MSG_DOWN)
        down_pend_reg <= 1'b0;
      if (fault_in && fcfg_reg[mrpc_pkg::FLT_SPREAD_BIT]
          && state_reg != mrpc_pkg::ST_OFF
          && state_reg != mrpc_pkg::ST_FAULT)
        fault_pend_reg <= 1'b1;  // see R14
      if (state_reg == mrpc_pkg::ST_WAIT_UP && !fault_in && !heard_fault
          && en_s_reg[1]
          && (!prev_reg[mrpc_pkg::ID_VALID_BIT] || heard_up))
        up_pend_reg <= 1'b1;  // see R13
      if (state_reg == mrpc_pkg::ST_WAIT_DOWN && !fault_in
          && !heard_fault
          && (!next_reg[mrpc_pkg::ID_VALID_BIT] || heard_down))
        down_pend_reg <= 1'b1;  // see R13
    end

  // ==========================================================
  // Transmitter; only ever pulls low, the pull-up releases
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= 9'h1FF;
      tx_bit_reg   <= 4'h0;
      tx_cnt_reg   <= 10'h000;
    end
    else if (!tx_busy_reg)
    begin
      if (tx_start)
      begin
        tx_busy_reg  <= 1'b1;
        tx_shift_reg <= {1'b0, tx_type, addr_reg[5:0]};
        tx_bit_reg   <= 4'h0;
        tx_cnt_reg   <= 10'h000;
      end
    end
    else if (tx_cnt_reg == mrpc_pkg::BIT_CYC - 10'h001)
    begin
      tx_cnt_reg <= 10'h000;
      if (tx_bit_reg == mrpc_pkg::STOP_BIT)
        tx_busy_reg <= 1'b0;
      else
      begin
        tx_shift_reg <= {tx_shift_reg[7:0], 1'b1};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
      end
    end
    else
      tx_cnt_reg <= tx_cnt_reg + 10'h001;

  assign link.dev_out = 1'b0;
  assign link.dev_oe  = tx_busy_reg && !tx_shift_reg[8];  // see R3

  assign bus_address     = addr_reg;
  assign phase_offset    = phase_reg;
  assign rail_on         = rail_reg;
  assign reference_level = ref_reg;
  assign seq_state       = state_reg;
endmodule

// File: mrpc_link_if.sv
// Inter-device bus and shared enable between a device and a peer.
// Resolves the wired open-drain line with a single pull-up.
`timescale 1ns/1ps
interface mrpc_link_if;
  logic dev_out;
  logic dev_oe;
  logic peer_out;
  logic peer_oe;
  logic bus_level;
  logic group_enable;

  // Pull-up wins unless some driver pulls low
  assign bus_level = !((dev_oe && !dev_out) || (peer_oe && !peer_out));

  modport device (output dev_out, output dev_oe,
                  input bus_level, input group_enable);
  modport peer (output peer_out, output peer_oe,
                output group_enable, input bus_level);
endinterface

// File: mrpc_peer.sv
// Far end of the coordination link: drives the group enable and
// exchanges frames on the shared inter-device bus.
// Assumes the same clock as the device end.
`timescale 1ns/1ps
module mrpc_peer (
  input  wire logic       clk,
  input  wire logic       rstn,
  mrpc_link_if.peer       link,
  input  wire logic       enable_request,
  input  wire logic       send_valid,
  input  wire logic [1:0] send_type,
  input  wire logic [5:0] send_id,
  output logic            send_ready,
  output logic            rx_valid,
  output logic [1:0]      rx_type,
  output logic [5:0]      rx_id
);
  logic       en_reg;
  logic       line_s1_reg, line_s2_reg, line_d_reg;
  logic       tx_busy_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_cnt_reg;
  logic       rx_busy_reg;
  logic [3:0] rx_bit_reg;
  logic [9:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_valid_reg;

  // ==========================================================
  // Shared enable, one wire for the whole group
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      en_reg <= 1'b0;
    else
      en_reg <= enable_request;  // see R13

  assign link.group_enable = en_reg;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      line_s1_reg <= 1'b1;
      line_s2_reg <= 1'b1;
      line_d_reg  <= 1'b1;
    end
    else
    begin
      line_s1_reg <= link.bus_level;
      line_s2_reg <= line_s1_reg;
      line_d_reg  <= line_s2_reg;
    end

  // ==========================================================
  // Transmitter, open drain only
  assign send_ready = !tx_busy_reg && !rx_busy_reg && line_s2_reg;

  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= 9'h1FF;
      tx_bit_reg   <= 4'h0;
      tx_cnt_reg   <= 10'h000;
    end
    else if (!tx_busy_reg)
    begin
      if (send_valid && send_ready)
      begin
        tx_busy_reg  <= 1'b1;
        tx_shift_reg <= {1'b0, send_type, send_id};
        tx_bit_reg   <= 4'h0;
        tx_cnt_reg   <= 10'h000;
      end
    end
    else if (tx_cnt_reg == mrpc_pkg::BIT_CYC - 10'h001)
    begin
      tx_cnt_reg <= 10'h000;
      if (tx_bit_reg == mrpc_pkg::STOP_BIT)
        tx_busy_reg <= 1'b0;
      else
      begin
        tx_shift_reg <= {tx_shift_reg[7:0], 1'b1};
        tx_bit_reg   <= tx_bit_reg + 4'h1;
      end
    end
    else
      tx_cnt_reg <= tx_cnt_reg + 10'h001;

  assign link.peer_out = 1'b0;
  assign link.peer_oe  = tx_busy_reg && !tx_shift_reg[8];  // see R4

  // ==========================================================
  // Receiver, samples mid-bit; own frames are not reported
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      rx_busy_reg  <= 1'b0;
      rx_bit_reg   <= 4'h0;
      rx_cnt_reg   <= 10'h000;
      rx_shift_reg <= 8'h00;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      rx_valid_reg <= 1'b0;
      if (!rx_busy_reg)
      begin
        if (line_d_reg && !line_s2_reg)
        begin
          rx_busy_reg <= 1'b1;
          rx_bit_reg  <= 4'h0;
          rx_cnt_reg  <= 10'h000;
        end
      end
      else
      begin
        if (rx_cnt_reg == mrpc_pkg::BIT_CYC - 10'h001)
        begin
          rx_cnt_reg <= 10'h000;
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        else
          rx_cnt_reg <= rx_cnt_reg + 10'h001;
        if (rx_cnt_reg == mrpc_pkg::HALF_CYC)
        begin
          if (rx_bit_reg == 4'h0)
            rx_busy_reg <= !line_s2_reg;
          else
            rx_shift_reg <= {rx_shift_reg[6:0], line_s2_reg};
          if (rx_bit_reg == mrpc_pkg::LAST_DATA_BIT)
          begin
            rx_busy_reg  <= 1'b0;
            rx_valid_reg <= !tx_busy_reg;
          end
        end
      end
    end

  assign rx_valid = rx_valid_reg;
  assign rx_type  = rx_shift_reg[7:6];
  assign rx_id    = rx_shift_reg[5:0];
endmodule

// File: mrpc_pkg.sv
// Shared constants of the multi-rail power coordination block.
// Assumes one 200 MHz clock shared by both ends of the link.
package mrpc_pkg;

  // ==========================================================
  // Address strap
  localparam logic [1:0] STRAP_RESISTOR = 2'h0;
  localparam logic [1:0] STRAP_SIGNAL_GROUND     = 2'h1;
  localparam logic [1:0] STRAP_OPEN     = 2'h2;
  localparam logic [1:0] STRAP_REGOUT   = 2'h3;
  localparam logic [6:0] ADDR_LOWEST    = 7'h19;
  localparam logic [6:0] ADDR_HIGHEST   = 7'h31;
  localparam logic [6:0] ADDR_SIGNAL_GROUND      = 7'h23;
  localparam logic [6:0] ADDR_OPEN      = 7'h24;
  localparam logic [6:0] ADDR_REGOUT    = 7'h25;
  localparam logic [4:0] STRAP_LAST_IDX = 5'h18;
  localparam logic [1:0] STRAP_SETTLE   = 2'h3;

  // ==========================================================
  // Management commands
  localparam logic [2:0] CMD_PHASE      = 3'h0;
  localparam logic [2:0] CMD_TRACK_CFG  = 3'h1;
  localparam logic [2:0] CMD_TRACK_RAT  = 3'h2;
  localparam logic [2:0] CMD_PREV_ID    = 3'h3;
  localparam logic [2:0] CMD_NEXT_ID    = 3'h4;
  localparam logic [2:0] CMD_FAULT_CFG  = 3'h5;
  localparam int         TRK_EN_BIT     = 0;
  localparam int         TRK_RATIO_BIT  = 1;
  localparam int         TRK_LIMIT_BIT  = 2;
  localparam int         FLT_SPREAD_BIT = 0;
  localparam int         FLT_RESTART_BIT = 1;
  localparam int         ID_VALID_BIT   = 7;

  // ==========================================================
  // Reset values
  localparam logic [3:0] PHASE_RESET    = 4'h0;
  localparam logic [7:0] RATIO_RESET    = 8'h80;
  localparam logic [2:0] TRACK_RESET    = 3'h0;
  localparam logic [1:0] FAULT_RESET    = 2'h0;

  // ==========================================================
  // Inter-device bus frames: start bit, type, id, stop bit
  localparam logic [1:0] MSG_UP         = 2'h1;
  localparam logic [1:0] MSG_DOWN       = 2'h2;
  localparam logic [1:0] MSG_FAULT      = 2'h3;
  localparam int         CLK_MHZ        = 200;
  localparam int         BIT_NS         = 2000;
  localparam logic [9:0] BIT_CYC  = 10'(BIT_NS * CLK_MHZ / 1000);
  localparam logic [9:0] HALF_CYC = 10'(BIT_NS * CLK_MHZ / 2000);
  localparam logic [3:0] LAST_DATA_BIT  = 4'h8;
  localparam logic [3:0] STOP_BIT       = 4'h9;

  // ==========================================================
  // Sequencer states, Gray along off-up-on-down
  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_WAIT_UP   = 3'b001,
    ST_ON        = 3'b011,
    ST_WAIT_DOWN = 3'b010,
    ST_FAULT     = 3'b110
  } mrpc_state_type;

endpackage

// File: multi_rail_power_coordination_bench.sv
// Bench joining the device end and the peer end over the link.
// Assumes the link interface resolves the open-drain line.
`timescale 1ns/1ps
module multi_rail_power_coordination_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [1:0]  strap_kind = 2'h0;
  logic [4:0]  strap_index = 5'h00;
  logic        ratio_strap_valid = 1'b0;
  logic [7:0]  ratio_strap = 8'h00;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_code = 3'h0;
  logic [7:0]  cmd_data = 8'h00;
  logic        fault_in = 1'b0;
  logic [11:0] tracking_reference_input = 12'hC00;
  logic [11:0] output_target_level = 12'h400;
  logic        enable_request = 1'b0;
  logic        send_valid = 1'b0;
  logic [1:0]  send_type = 2'h0;
  logic [5:0]  send_id = 6'h00;
  logic [6:0]  bus_address;
  logic [3:0]  phase_offset;
  logic        rail_on;
  logic [11:0] reference_level;
  logic [2:0]  seq_state;
  logic        send_ready;
  logic        rx_valid;
  logic [1:0]  rx_type;
  logic [5:0]  rx_id;
  int          num_errors = 0;
  int          checks_done = 0;
  // Strap kind, index, address; tracking config, reference
  logic [13:0] straps [7] = '{14'h0019, 14'h0C31, 14'h0523, 14'h0F31,
                              14'h1023, 14'h2024, 14'h3025};
  logic [14:0] tracks [4] = '{15'h1400, 15'h5C00, 15'h3200, 15'h7400};

  mrpc_link_if link();
  mrpc_device i_mrpc_device (.clk, .rstn, .link(link.device), .strap_kind,
    .strap_index, .ratio_strap_valid, .ratio_strap, .cmd_valid, .cmd_code,
    .cmd_data, .fault_in, .tracking_reference_input, .output_target_level,
    .bus_address, .phase_offset, .rail_on, .reference_level, .seq_state);
  mrpc_peer i_mrpc_peer (.clk, .rstn, .link(link.peer), .enable_request,
    .send_valid, .send_type, .send_id, .send_ready, .rx_valid, .rx_type,
    .rx_id);
  mrpc_checker i_mrpc_checker (.clk, .rstn, .dev_out(link.dev_out),
    .dev_oe(link.dev_oe), .peer_out(link.peer_out), .peer_oe(link.peer_oe),
    .bus_level(link.bus_level), .group_enable(link.group_enable));

  always #2.5 clk = ~clk;

  // ========
  // Tasks
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(string name, logic [11:0] exp, logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    tick(4);
    rstn <= 1'b1;
    tick(8);
  endtask

  task automatic cmd(logic [2:0] code, logic [7:0] data);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_data <= data;
    tick(1);
    cmd_valid <= 1'b0;
    tick(3);
  endtask

  // Frames take 4000 cycles, so waits are bounded at 6000
  task automatic expect_frame(logic [1:0] kind, logic [5:0] id);
    int n;
    n = 0;
    do
      tick(1);
    while (rx_valid !== 1'b1 && ++n < 6000);
    chk("frame seen", 12'h001, 12'(rx_valid));
    chk("frame type", 12'(kind), 12'(rx_type));
    chk("frame id", 12'(id), 12'(rx_id));
  endtask

  task automatic send(logic [1:0] kind, logic [5:0] id);
    int n;
    n = 0;
    send_valid <= 1'b1;
    send_type <= kind;
    send_id <= id;
    do
      tick(1);
    while (send_ready !== 1'b1 && ++n < 6000);
    chk("send ready", 12'h001, 12'(send_ready));
    send_valid <= 1'b0;
  endtask

  task automatic wait_rail(logic v, logic [2:0] state);
    int n;
    n = 0;
    while (rail_on !== v && n < 6000)
    begin
      tick(1);
      n++;
    end
    chk("rail", 12'(v), 12'(rail_on));
    chk("state", 12'(state), 12'(seq_state));
  endtask

  // ========
  // Tests
  initial
  begin
    foreach (straps[i])
    begin
      {strap_kind, strap_index} <= straps[i][13:7];
      do_reset();
      chk("address", 12'(straps[i][6:0]), 12'(bus_address));
    end
    strap_kind <= 2'h0;
    tick(10);
    chk("address", 12'h025, 12'(bus_address));
    chk("phase", 12'h000, 12'(phase_offset));
    cmd(3'h0, 8'h0F);
    cmd(3'h6, 8'h03);
    chk("phase", 12'h00F, 12'(phase_offset));
    chk("reference", 12'h400, reference_level);
    foreach (tracks[i])
    begin
      cmd(3'h1, {5'h00, tracks[i][14:12]});
      chk("reference", tracks[i][11:0], reference_level);
    end
    cmd(3'h2, 8'h40);
    cmd(3'h1, 8'h03);
    chk("reference", 12'h100, reference_level);
    cmd(3'h1, 8'h00);
    cmd(3'h5, 8'h01);
    enable_request <= 1'b1;
    expect_frame(mrpc_pkg::MSG_UP, 6'h25);
    wait_rail(1'b1, 3'b011);
    send(mrpc_pkg::MSG_FAULT, 6'h01);
    wait_rail(1'b0, 3'b110);
    enable_request <= 1'b0;
    tick(10);
    wait_rail(1'b0, 3'b000);
    cmd(3'h5, 8'h03);
    enable_request <= 1'b1;
    expect_frame(mrpc_pkg::MSG_UP, 6'h25);
    fault_in <= 1'b1;
    expect_frame(mrpc_pkg::MSG_FAULT, 6'h25);
    wait_rail(1'b0, 3'b110);
    fault_in <= 1'b0;
    expect_frame(mrpc_pkg::MSG_UP, 6'h25);
    enable_request <= 1'b0;
    expect_frame(mrpc_pkg::MSG_DOWN, 6'h25);
    wait_rail(1'b0, 3'b000);
    cmd(3'h3, 8'h91);
    enable_request <= 1'b1;
    tick(20);
    wait_rail(1'b0, 3'b001);
    send(mrpc_pkg::MSG_UP, 6'h11);
    wait_rail(1'b1, 3'b011);
    ratio_strap_valid <= 1'b1;
    ratio_strap <= 8'h40;
    do_reset();
    cmd(3'h1, 8'h03);
    chk("reference", 12'h100, reference_level);
    stop_test();
  end

  initial
  begin
    tick(60000);
    num_errors++;
    stop_test();
  end
endmodule
